/* vaa_map.svh */
// timing counts, widths and pattern figures for the alarm annunciator
`ifndef VAA_MAP_SVH
`define VAA_MAP_SVH
`define VAA_CLK_NS       10          // system clock period, ns
`define VAA_TICK_NS      1000000     // timer tick, ns (1 ms)
`define VAA_TICK_CYC     (`VAA_TICK_NS / `VAA_CLK_NS)
`define VAA_PW           17          // prescaler width
`define VAA_TW           17          // millisecond timer width
`define VAA_NW           4           // pulse counter width
`define VAA_ONE_MS       17'h00001   // one tick
`define VAA_RED_HALF_MS  17'h000fa   // 250 ms: two flashes per second
`define VAA_YEL_HALF_MS  17'h003e8   // 1000 ms: thirty per minute
`define VAA_GREEN_MS     17'h00064   // 100 ms green flash
`define VAA_ESC_CYCLES   2'h3        // venting cycles in a row
`define VAA_VENT_LONG_MS 17'h003e8   // 1 s of venting
`define VAA_HOLD_MS      17'h02710   // 10 s hold after last detection
`define VAA_PEEP_MS      17'h02710   // 10 s of high end pressure
`define VAA_NOACT_MS     17'h02710   // 10 s without cycle or breath
`define VAA_TONE_ON_MS   17'h00064   // tone pulse length
`define VAA_TONE_OFF_MS  17'h00064   // space between pulses
`define VAA_SPLIT_MS     17'h001f4   // space between the two bursts
`define VAA_HI_PULSES    4'ha        // two bursts of five
`define VAA_HI_SPLIT     4'h5        // pulse after which the split falls
`define VAA_MED_PULSES   4'h3        // one burst of three
`define VAA_SLOW_MS      17'h02710   // 6 bursts per minute
`define VAA_FAST_MS      17'h01388   // 12 bursts per minute
`define VAA_RAMP_FROM_MS 17'h0ea60   // ramp starts at 60 s
`define VAA_RAMP_TO_MS   17'h1d4c0   // ramp ends at 120 s
`define VAA_RAMP_DIV     4'hc        // shorten period 1 ms per 12 ms
`endif

/* vaa_pkg.sv */
// types shared by the alarm annunciator
package vaa_pkg;
    // sounder sequencer states, one-hot
    typedef enum logic [3:0] {
        SND_IDLE = 4'h1,
        SND_TONE = 4'h2,
        SND_GAP  = 4'h4,
        SND_WAIT = 4'h8
    } vaa_snd_t;
    // pneumatic sensing inputs
    typedef struct packed {
        logic relief_vent;   // relief valve venting to atmosphere
        logic press_above;   // inflation pressure above threshold
        logic demand_breath; // demand detector sees a breath
        logic peep_high;     // end-expiratory pressure over limit
    } vaa_sense_t;
    // lamp drives, high lights the lamp
    typedef struct packed {
        logic red;           // high inflation pressure
        logic yellow;        // low pressure or disconnect
        logic cycle;         // cycle indicator, green
        logic breath;        // breathing detect, green
    } vaa_lamp_t;
endpackage

/* vaa_annunciator.sv */
// alarm annunciation: lamps and sounder patterns for a gas ventilator
// Overview of operation
// [RL1] red lamp blinks 2 Hz while venting
// [RL2] 3 cycles or 1 s escalates alarm
// [RL3] escalation holds 10 s then clears
// [RL4] high end pressure 10 s escalates too
// [RL5] 10 s inactivity: yellow 30/min, medium sound
// [RL6] breath lights green lamp 100 ms
// [RL7] threshold rise flashes cycle lamp 100 ms
// [RL8] high sound: two bursts of five, 6/min
// [RL9] medium sound: three pulses, 6/min first minute
// [RL10] second minute rate ramps to 12/min
// [RL11] high pattern wins; lamps stay independent
`timescale 1ns/1ps
`include "vaa_map.svh"

module vaa_annunciator #(
    parameter int unsigned TICK_CYC = `VAA_TICK_CYC // cycles per 1 ms tick
) (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire vaa_pkg::vaa_sense_t sense,
    output vaa_pkg::vaa_lamp_t       lamp,
    output logic                     sounder,
    output logic                     hi_alarm,
    output logic                     med_alarm
);

    // last prescaler count before a tick
    localparam logic [`VAA_PW-1:0] TICK_LAST = `VAA_PW'(TICK_CYC - 1);

    logic [`VAA_PW-1:0] pre;        // tick prescaler
    logic               press_q;    // threshold input, last cycle
    logic               breath_q;   // demand input, last cycle
    logic               vent_seen;  // venting seen in this breath cycle
    logic [1:0]         vent_run;   // breath cycles in a row with venting
    logic [`VAA_TW-1:0] vent_ms;    // length of the present venting
    logic [`VAA_TW-1:0] peep_ms;    // length of high end pressure
    logic [`VAA_TW-1:0] hold_ms;    // escalation hold time left
    logic [`VAA_TW-1:0] noact_ms;   // time since last cycle or breath
    logic [`VAA_TW-1:0] med_age;    // age of the medium alarm
    logic [`VAA_TW-1:0] med_per;    // present medium burst period
    logic [`VAA_NW-1:0] ramp_cnt;   // divides the ramp steps
    logic [`VAA_TW-1:0] red_ms;     // red blink phase timer
    logic               red_ph;     // red blink phase, high is lit
    logic [`VAA_TW-1:0] yel_ms;     // yellow blink phase timer
    logic               yel_ph;     // yellow blink phase
    logic [`VAA_TW-1:0] green_ms [2]; // green one-shots: 0 cycle, 1 breath
    vaa_pkg::vaa_snd_t  snd_st;     // sounder sequencer state
    logic [`VAA_NW-1:0] pulse_n;    // pulse number within the pattern
    logic [`VAA_TW-1:0] ph_ms;      // time spent in tone or space
    logic [`VAA_TW-1:0] per_ms;     // time since burst start
    logic               snd_hi;     // pattern of the running burst

    // decoded events and levels
    wire tick      = (pre == TICK_LAST);
    wire cyc_rise  = sense.press_above & ~press_q;
    wire brth_rise = sense.demand_breath & ~breath_q;
    wire run_full  = (vent_run == `VAA_ESC_CYCLES);
    wire vent_long = (vent_ms >= `VAA_VENT_LONG_MS);
    wire peep_long = (peep_ms >= `VAA_PEEP_MS);
    // any venting seen while escalated renews the hold
    wire relief_det = sense.relief_vent
                    & (run_full | vent_long | hi_alarm);
    wire peep_det   = sense.peep_high & peep_long;
    wire esc_det    = relief_det | peep_det;
    wire in_ramp    = (med_age >= `VAA_RAMP_FROM_MS)
                    & (med_age < `VAA_RAMP_TO_MS);
    wire ramp_step  = tick & med_alarm & in_ramp
                    & (ramp_cnt == `VAA_RAMP_DIV - 4'h1);
    wire any_alarm  = hi_alarm | med_alarm;

    assign hi_alarm  = (hold_ms != '0); // [RL3]
    assign med_alarm = (noact_ms == `VAA_NOACT_MS); // [RL5]

    // sounder pattern decode for the running burst
    wire [`VAA_NW-1:0] pulses_all = snd_hi ? `VAA_HI_PULSES
                                           : `VAA_MED_PULSES; // [RL8] [RL9]
    wire [`VAA_TW-1:0] space_len  =
        (snd_hi && pulse_n == `VAA_HI_SPLIT) ? `VAA_SPLIT_MS
                                             : `VAA_TONE_OFF_MS; // [RL8]
    wire [`VAA_TW-1:0] period     = snd_hi ? `VAA_SLOW_MS : med_per;
    wire               ph_end     = tick & (ph_ms + `VAA_ONE_MS >=
                                   (snd_st == vaa_pkg::SND_TONE ?
                                    `VAA_TONE_ON_MS : space_len));
    wire               last_pulse = (pulse_n == pulses_all);

    // 1 ms tick prescaler
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            pre <= '0;
        else
            pre <= tick ? '0 : pre + `VAA_PW'(1);
    end

    // edge detection on the pneumatic switches
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            press_q  <= 1'b0;
            breath_q <= 1'b0;
        end
        else
        begin
            press_q  <= sense.press_above;
            breath_q <= sense.demand_breath;
        end
    end

    // count breath cycles in a row that saw the relief valve vent
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vent_seen <= 1'b0;
            vent_run  <= '0;
        end
        else if (cyc_rise)
        begin
            // a cycle without venting breaks the run
            vent_run  <= (vent_seen | sense.relief_vent)
                       ? (run_full ? vent_run : vent_run + 2'h1)
                       : '0; // [RL2]
            vent_seen <= sense.relief_vent;
        end
        else
            vent_seen <= vent_seen | sense.relief_vent;
    end

    // venting duration, saturates at the escalation time
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            vent_ms <= '0;
        else if (!sense.relief_vent)
            vent_ms <= '0;
        else if (tick && !vent_long)
            vent_ms <= vent_ms + `VAA_ONE_MS; // [RL2]
    end

    // high end pressure duration, must be unbroken
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            peep_ms <= '0;
        else if (!sense.peep_high)
            peep_ms <= '0;
        else if (tick && !peep_long)
            peep_ms <= peep_ms + `VAA_ONE_MS; // [RL4]
    end

    // escalation hold: reloaded on each detection, runs down after
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            hold_ms <= '0;
        else if (esc_det)
            hold_ms <= `VAA_HOLD_MS; // [RL2] [RL4]
        else if (tick && hi_alarm)
            hold_ms <= hold_ms - `VAA_ONE_MS; // [RL3]
    end

    // inactivity timer; starts at power-on, so an idle unit alarms
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            noact_ms <= '0;
        else if (cyc_rise || brth_rise)
            noact_ms <= '0; // [RL5]
        else if (tick && !med_alarm)
            noact_ms <= noact_ms + `VAA_ONE_MS;
    end

    // medium alarm age, saturates once the ramp is over
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            med_age <= '0;
        else if (!med_alarm)
            med_age <= '0;
        else if (tick && med_age < `VAA_RAMP_TO_MS)
            med_age <= med_age + `VAA_ONE_MS;
    end

    // medium period: slow for a minute, then shortened in steps
    // of 1 ms every 12 ms, reaching the fast rate at two minutes
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            med_per  <= `VAA_SLOW_MS;
            ramp_cnt <= '0;
        end
        else if (!med_alarm)
        begin
            med_per  <= `VAA_SLOW_MS; // [RL9]
            ramp_cnt <= '0;
        end
        else if (ramp_step)
        begin
            ramp_cnt <= '0;
            if (med_per > `VAA_FAST_MS)
                med_per <= med_per - `VAA_ONE_MS; // [RL10]
        end
        else if (tick && in_ramp)
            ramp_cnt <= ramp_cnt + `VAA_NW'(1);
    end

    // red blink, restarts lit each time venting begins
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            red_ms <= '0;
            red_ph <= 1'b1;
        end
        else if (!sense.relief_vent)
        begin
            red_ms <= '0;
            red_ph <= 1'b1;
        end
        else if (tick)
        begin
            if (red_ms + `VAA_ONE_MS >= `VAA_RED_HALF_MS)
            begin
                red_ms <= '0;
                red_ph <= ~red_ph; // [RL1]
            end
            else
                red_ms <= red_ms + `VAA_ONE_MS;
        end
    end

    // yellow blink, restarts lit when the disconnect alarm rises
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            yel_ms <= '0;
            yel_ph <= 1'b1;
        end
        else if (!med_alarm)
        begin
            yel_ms <= '0;
            yel_ph <= 1'b1;
        end
        else if (tick)
        begin
            if (yel_ms + `VAA_ONE_MS >= `VAA_YEL_HALF_MS)
            begin
                yel_ms <= '0;
                yel_ph <= ~yel_ph; // [RL5]
            end
            else
                yel_ms <= yel_ms + `VAA_ONE_MS;
        end
    end

    // green one-shots; a new edge retriggers the full flash
    for (genvar g = 0; g < 2; g++)
    begin : g_green
        wire trig = (g == 0) ? cyc_rise : brth_rise;
        always_ff @(posedge clk_sys or negedge arst_n)
        begin
            if (!arst_n)
                green_ms[g] <= '0;
            else if (trig)
                green_ms[g] <= `VAA_GREEN_MS; // [RL6] [RL7]
            else if (tick && green_ms[g] != '0)
                green_ms[g] <= green_ms[g] - `VAA_ONE_MS;
        end
    end

    // sounder sequencer next state
    vaa_pkg::vaa_snd_t  next_st;
    logic [`VAA_NW-1:0] next_pulse;
    logic               next_hi;
    logic               start;      // a new burst begins
    always_comb
    begin
        next_st    = snd_st;
        next_pulse = pulse_n;
        next_hi    = snd_hi;
        start      = 1'b0;
        unique case (snd_st)
            vaa_pkg::SND_IDLE:
                start = any_alarm;
            vaa_pkg::SND_TONE:
                if (ph_end)
                    next_st = last_pulse ? vaa_pkg::SND_WAIT
                                         : vaa_pkg::SND_GAP;
            vaa_pkg::SND_GAP:
                if (ph_end)
                begin
                    next_st    = vaa_pkg::SND_TONE;
                    next_pulse = pulse_n + `VAA_NW'(1);
                end
            vaa_pkg::SND_WAIT:
                // a high alarm does not wait out a medium period
                start = (per_ms >= period) | (hi_alarm & ~snd_hi); // [RL11]
        endcase
        if (start)
        begin
            next_st    = vaa_pkg::SND_TONE;
            next_pulse = `VAA_NW'(1);
            next_hi    = hi_alarm; // [RL11]
        end
        if (!any_alarm)
            next_st = vaa_pkg::SND_IDLE;
    end

    // sounder sequencer registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            snd_st  <= vaa_pkg::SND_IDLE;
            pulse_n <= '0;
            snd_hi  <= 1'b0;
            ph_ms   <= '0;
            per_ms  <= '0;
        end
        else
        begin
            snd_st  <= next_st;
            pulse_n <= next_pulse;
            snd_hi  <= next_hi;
            ph_ms   <= (start || ph_end) ? '0
                     : (tick ? ph_ms + `VAA_ONE_MS : ph_ms);
            per_ms  <= start ? '0
                     : (tick ? per_ms + `VAA_ONE_MS : per_ms); // [RL8]
        end
    end

    // registered outputs; escalation shows the red lamp steady
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lamp    <= '0;
            sounder <= 1'b0;
        end
        else
        begin
            lamp.red    <= hi_alarm | (sense.relief_vent & red_ph); // [RL1] [RL2]
            lamp.yellow <= med_alarm & yel_ph; // [RL5]
            lamp.cycle  <= (green_ms[0] != '0); // [RL7]
            lamp.breath <= (green_ms[1] != '0); // [RL6]
            sounder     <= (next_st == vaa_pkg::SND_TONE);
        end
    end

endmodule

/* vaa_annunciator_properties.sv */
// port checks for the alarm annunciator
`timescale 1ns/1ps

module vaa_annunciator_properties #(
    parameter int unsigned TICK_CYC = 100000 // cycles per tick
) (
    input wire logic                clk_sys,
    input wire logic                arst_n,
    input wire vaa_pkg::vaa_sense_t sense,
    input wire vaa_pkg::vaa_lamp_t  lamp,
    input wire logic                sounder,
    input wire logic                hi_alarm,
    input wire logic                med_alarm
);
    // one clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    cycle_flash_a: assert property (
        $rose(sense.press_above) |-> ##[1:3] lamp.cycle)
        else $error("cycle lamp missed a rise");
    breath_flash_a: assert property (
        $rose(sense.demand_breath) |-> ##[1:3] lamp.breath)
        else $error("breath lamp missed a breath");
    red_steady_a: assert property (
        hi_alarm && $past(hi_alarm) && $past(hi_alarm, 2) |-> lamp.red)
        else $error("red lamp not steady");
    hold_renew_a: assert property (
        hi_alarm && sense.relief_vent |=> hi_alarm)
        else $error("high alarm dropped while venting");
    hi_sound_a: assert property (
        $rose(hi_alarm) && !med_alarm |-> ##[1:3] sounder)
        else $error("no tone after high alarm");
    // one flop stage, the sounder register, sits between the alarms and the tone
    quiet_idle_a: assert property (
        (!hi_alarm && !med_alarm) [*3] |-> !sounder)
        else $error("tone without alarm");
    yellow_cause_a: assert property (
        lamp.yellow |-> med_alarm || $past(med_alarm)
            || $past(med_alarm, 2))
        else $error("yellow without medium alarm");
    activity_clear_a: assert property (
        $rose(sense.press_above) |-> ##4 !med_alarm)
        else $error("medium alarm kept after a cycle");

    cover property ($rose(hi_alarm));
    cover property ($rose(med_alarm));
    cover property ($rose(hi_alarm) && med_alarm);
endmodule

bind vaa_annunciator vaa_annunciator_properties #(
    .TICK_CYC(TICK_CYC)
) i_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .sense(sense), .lamp(lamp),
    .sounder(sounder), .hi_alarm(hi_alarm), .med_alarm(med_alarm)
);

/* vaa_pneumatics.sv */
// pneumatic sensing stand-in: cycles, venting, demand breaths, end pressure
`timescale 1ns/1ps

module vaa_pneumatics #(
    parameter int unsigned TICK_CYC = 1 // cycles per tick
) (
    input  wire logic           clk_sys,
    input  wire logic           cycle_en,
    input  wire logic           vent_cycle,
    input  wire logic           vent_steady,
    input  wire logic           breath_en,
    input  wire logic           peep_on,
    output vaa_pkg::vaa_sense_t sense
);
    int unsigned cyc_t = 0; // clocks into the 2000 tick breath cycle
    int unsigned brt_t = 0; // clocks into the 3000 tick demand cycle
    logic        press;     // inflation above threshold
    logic        vent;      // relief valve venting
    logic        breath;    // demand detector active
    // falling edge so the block always samples settled switches
    always @(negedge clk_sys)
    begin
        cyc_t <= cycle_en ? (cyc_t + 1) % (2000 * TICK_CYC) : 0;
        brt_t <= breath_en ? (brt_t + 1) % (3000 * TICK_CYC) : 0;
    end
    // venting per cycle starts with the rise, so it is seen at the edge
    assign press  = cycle_en && (cyc_t < 300 * TICK_CYC);
    assign vent   = vent_steady || (vent_cycle && press);
    assign breath = breath_en && (brt_t < 50 * TICK_CYC);
    assign sense  = {vent, press, breath, peep_on};
endmodule

/* vaa_annunciator_tb.sv */
// self-checking bench for the alarm annunciator
`timescale 1ns/1ps

module vaa_annunciator_tb;
    localparam int unsigned TC = 1; // one clock per tick keeps runs short
    logic                clk_sys = 1'b0;
    logic                arst_n = 1'b0;
    logic                cycle_en = 1'b0;
    logic                vent_cycle = 1'b0;
    logic                vent_steady = 1'b0;
    logic                breath_en = 1'b0;
    logic                peep_on = 1'b0;
    vaa_pkg::vaa_sense_t sense;
    vaa_pkg::vaa_lamp_t  lamp;
    logic                sounder;
    logic                hi_alarm;
    logic                med_alarm;
    int                  mismatches = 0;
    int                  checked = 0;

    always #5 clk_sys = ~clk_sys;

    vaa_pneumatics #(.TICK_CYC(TC)) i_model (
        .clk_sys(clk_sys), .cycle_en(cycle_en), .vent_cycle(vent_cycle),
        .vent_steady(vent_steady), .breath_en(breath_en),
        .peep_on(peep_on), .sense(sense));
    vaa_annunciator #(.TICK_CYC(TC)) i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .sense(sense), .lamp(lamp),
        .sounder(sounder), .hi_alarm(hi_alarm), .med_alarm(med_alarm));

    task automatic complete_run;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok)
        begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n * TC) @(negedge clk_sys);
    endtask

    // bounded wait for one alarm; running out ends the run
    task automatic wait_for(input int bound, input bit med);
        int n;
        n = 0;
        while ((med ? med_alarm : hi_alarm) !== 1'b1)
        begin
            if (n == bound * TC)
            begin
                chk(1'b0, "alarm late");
                complete_run();
            end
            n++;
            @(negedge clk_sys);
        end
    endtask

    // counts tone starts over a stretch of ticks
    task automatic rises(input int t, output int k);
        logic prev;
        prev = sounder;
        k = 0;
        repeat (t * TC)
        begin
            @(negedge clk_sys);
            if (sounder === 1'b1 && prev === 1'b0)
                k++;
            prev = sounder;
        end
    endtask

    // every scenario starts from a fresh reset, so old counts cannot leak
    task automatic restart;
        {cycle_en, vent_cycle, vent_steady, breath_en, peep_on} = 5'h00;
        arst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
    endtask

    task automatic green_flash;
        restart();
        breath_en = 1'b1;
        cycle_en = 1'b1;
        ticks(5);
        chk(lamp.breath === 1'b1, "breath lamp dark");
        chk(lamp.cycle === 1'b1, "cycle lamp dark");
        ticks(90);
        chk(lamp.breath === 1'b1, "breath flash short");
        chk(lamp.cycle === 1'b1, "cycle flash short");
        ticks(12);
        chk(lamp.breath === 1'b0, "breath flash long");
        chk(lamp.cycle === 1'b0, "cycle flash long");
    endtask

    task automatic red_escalate;
        int k;
        int j;
        restart();
        breath_en = 1'b1;
        vent_steady = 1'b1;
        ticks(100);
        chk(lamp.red === 1'b1, "red dark");
        ticks(250);
        chk(lamp.red === 1'b0, "red not blinking");
        ticks(250);
        chk(lamp.red === 1'b1 && hi_alarm === 1'b0, "red blink");
        wait_for(500, 1'b0);
        rises(300, j);
        chk(lamp.red === 1'b1, "red not steady");
        // the ten tones end about 2300 ticks in; the next burst is far off
        rises(3700, k);
        chk(j + k == 10, "high pulse count");
    endtask

    task automatic three_cycles;
        restart();
        cycle_en = 1'b1;
        vent_cycle = 1'b1;
        ticks(3900);
        chk(hi_alarm === 1'b0, "escalated after two cycles");
        wait_for(2300, 1'b0);
        vent_cycle = 1'b0;
        ticks(9800);
        chk(hi_alarm === 1'b1 && lamp.red === 1'b1, "hold short");
        ticks(400);
        chk({hi_alarm, lamp.red, sounder} === 3'h0, "hold stuck");
    endtask

    task automatic medium_high;
        int k;
        restart();
        ticks(9900);
        chk(med_alarm === 1'b0, "medium early");
        wait_for(200, 1'b1);
        rises(500, k);
        chk(k == 3 && lamp.yellow === 1'b1, "medium burst");
        rises(1000, k);
        chk(k == 0 && lamp.yellow === 1'b0, "yellow blink");
        rises(7500, k);
        chk(k == 0, "medium repeat early");
        peep_on = 1'b1;
        rises(1500, k);
        chk(k == 3, "medium period");
        ticks(8300);
        chk(hi_alarm === 1'b0, "end pressure early");
        wait_for(400, 1'b0);
        rises(9000, k);
        chk(k == 10 && lamp.red === 1'b1, "high over medium");
        chk(med_alarm === 1'b1, "medium lost");
        peep_on = 1'b0;
        // bursts keep a 10000 tick spacing up to the one near 69006;
        // the ramp from an alarm age of 60000 pulls the next one in to
        // about 78315, where a steady rate would not start before 79007
        ticks(31600);
        chk(hi_alarm === 1'b0, "high kept after end pressure");
        rises(9250, k);
        chk(k == 3, "medium rate not ramping");
    endtask

    initial
    begin
        green_flash();
        red_escalate();
        three_cycles();
        medium_high();
        complete_run();
    end
endmodule
